// >>> rtl/ccirq_pkg.sv
// package: flags register layout, offsets and priority encodings
package ccirq_pkg;
    // ---------------------------------------------------------------
    // flags register bits
    // ---------------------------------------------------------------
    localparam int BIT_CARRY     = 0;
    localparam int BIT_ZERO      = 1;
    localparam int BIT_NEG       = 2;
    localparam int BIT_MASK_LO   = 3;
    localparam int BIT_NIBBLE    = 4;
    localparam int BIT_MASK_HI   = 5;
    localparam int BIT_ONE_LO    = 6;
    localparam int BIT_ONE_HI    = 7;
    localparam int RES_MSB       = 7;
    localparam int NIB_BIT       = 4;
    localparam logic [7:0] FLAGS_RESET    = 8'he8;
    localparam logic [7:0] FLAGS_ONE_MASK = 8'hc0;
    // ---------------------------------------------------------------
    // software priority codes (upper, lower)
    // ---------------------------------------------------------------
    localparam logic [1:0] PRIO_LVL0 = 2'h2;
    localparam logic [1:0] PRIO_LVL1 = 2'h1;
    localparam logic [1:0] PRIO_LVL2 = 2'h0;
    localparam logic [1:0] PRIO_LVL3 = 2'h3;
    // ---------------------------------------------------------------
    // sources: 0..4 numbered, 5 is the top level pin
    // ---------------------------------------------------------------
    localparam int NSRC = 6;
    localparam int SRC_TOP = 5;
    localparam logic [2:0] SRC_NONE = 3'h7;
    // ---------------------------------------------------------------
    // wishbone map (word addresses in bytes)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_FLAGS   = 8'h00;
    localparam logic [7:0] ADR_PRIO    = 8'h04;
    localparam logic [7:0] ADR_HALTCAP = 8'h08;
    localparam logic [7:0] ADR_STATUS  = 8'h0c;
    localparam logic [7:0] ADR_CTRL    = 8'h10;
    localparam logic [11:0] PRIO_RESET    = 12'hfff;
    localparam logic [5:0]  HALTCAP_RESET = 6'h21;
    // ---------------------------------------------------------------
    // flag update operations from the datapath
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        CCIRQ_OP_NONE, CCIRQ_OP_ADD, CCIRQ_OP_ARITH, CCIRQ_OP_LOGIC,
        CCIRQ_OP_SHIFT, CCIRQ_OP_BTJ, CCIRQ_OP_SCF, CCIRQ_OP_RCF,
        CCIRQ_OP_MASK_CLR, CCIRQ_OP_MASK_SET, CCIRQ_OP_RET, CCIRQ_OP_POP,
        CCIRQ_OP_HALT, CCIRQ_OP_WAIT
    } ccirq_op_e;
endpackage : ccirq_pkg

// >>> rtl/ccirq_core.sv
// condition flags register with interrupt priority arbitration
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ccirq_core (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // datapath flag update
    input  wire logic                 op_valid,
    input  wire ccirq_pkg::ccirq_op_e op_code,
    input  wire logic [7:0]           op_result,
    input  wire logic                 op_carry,
    input  wire logic                 op_nibble_carry,
    input  wire logic [7:0]           op_pop_data,
    input  wire logic [1:0]           op_mask_data,
    // interrupt requests and entry handshake
    input  wire logic [5:0]           irq_pending,
    input  wire logic                 irq_ack,
    // flags and interrupt outputs
    output logic [7:0]                flags_register,
    output logic                      irq_take,
    output logic [2:0]                irq_source,
    output logic                      low_power,
    output logic                      in_halt,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o
);
    import ccirq_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum {CCIRQ_RUN, CCIRQ_WAIT, CCIRQ_HALT} ccirq_pwr_e;

    logic [7:0]  flags_reg,   flags_next;
    logic [11:0] prio_reg,    prio_next;
    logic [5:0]  haltcap_reg, haltcap_next;
    logic        nested_reg,  nested_next;
    logic [2:0]  depth_reg,   depth_next;
    logic        from_halt_reg, from_halt_next;
    ccirq_pwr_e  pwr_reg,     pwr_next;
    logic        take_reg,    take_next;
    logic [2:0]  src_reg,     src_next;
    logic [31:0] rdat_reg,    rdat_next;
    logic        ack_reg,     ack_next;
    logic        err_reg,     err_next;

    logic [1:0]  cur_lvl;
    logic [1:0]  src_lvl [NSRC];
    logic [5:0]  eligible;
    logic [2:0]  win_src;
    logic [1:0]  win_lvl;
    logic        win_any;
    logic        wb_req;
    logic        mapped;

    // ---------------------------------------------------------------
    // priority level decode
    // ---------------------------------------------------------------
    // mask pair decode
    function automatic logic [1:0] lvl_of(input logic [1:0] code);
        case (code)
            PRIO_LVL0: lvl_of = 2'h0;
            PRIO_LVL1: lvl_of = 2'h1;
            PRIO_LVL2: lvl_of = 2'h2;
            default:   lvl_of = 2'h3;
        endcase
    endfunction : lvl_of

    assign cur_lvl = lvl_of({flags_reg[BIT_MASK_HI], flags_reg[BIT_MASK_LO]});

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign src_lvl[gi] = lvl_of(prio_reg[2*gi +: 2]);
            assign eligible[gi] = irq_pending[gi] && (pwr_reg != CCIRQ_HALT || haltcap_reg[gi]);
        end
    endgenerate

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    always_comb begin
        int s;
        s       = 0;
        win_src = SRC_NONE;
        win_lvl = 2'h0;
        win_any = 1'b0;
        // fixed order ties
        // visit pin first, then source 0 up to source 4; strict compare keeps the earlier one on ties
        // higher level wins
        for (int k = 0; k < NSRC; k++) begin
            s = (k == 0) ? SRC_TOP : k - 1;
            if (eligible[s] && (!win_any || src_lvl[s] > win_lvl)) begin
                win_any = 1'b1;
                win_lvl = src_lvl[s];
                win_src = s[2:0];
            end
        end
    end

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign mapped = wb_adr_i == ADR_FLAGS || wb_adr_i == ADR_PRIO || wb_adr_i == ADR_HALTCAP
                 || wb_adr_i == ADR_STATUS || wb_adr_i == ADR_CTRL;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        flags_next     = flags_reg;
        prio_next      = prio_reg;
        haltcap_next   = haltcap_reg;
        nested_next    = nested_reg;
        depth_next     = depth_reg;
        from_halt_next = from_halt_reg;
        pwr_next       = pwr_reg;
        take_next      = take_reg;
        src_next       = src_reg;
        rdat_next      = 32'h0;
        ack_next       = 1'b0;
        err_next       = 1'b0;

        if (op_valid) begin
            case (op_code)
                CCIRQ_OP_ADD: begin
                    flags_next[BIT_NIBBLE] = op_nibble_carry;
                    flags_next[BIT_NEG]    = op_result[RES_MSB];
                    flags_next[BIT_ZERO]   = op_result == 8'h00;
                    flags_next[BIT_CARRY]  = op_carry;
                end
                CCIRQ_OP_ARITH, CCIRQ_OP_SHIFT: begin
                    flags_next[BIT_NEG]   = op_result[RES_MSB];
                    flags_next[BIT_ZERO]  = op_result == 8'h00;
                    flags_next[BIT_CARRY] = op_carry;
                end
                CCIRQ_OP_LOGIC: begin
                    flags_next[BIT_NEG]  = op_result[RES_MSB];
                    flags_next[BIT_ZERO] = op_result == 8'h00;
                end
                CCIRQ_OP_BTJ: flags_next[BIT_CARRY] = op_carry;
                CCIRQ_OP_SCF: flags_next[BIT_CARRY] = 1'b1;
                CCIRQ_OP_RCF: flags_next[BIT_CARRY] = 1'b0;
                CCIRQ_OP_MASK_CLR: begin
                    flags_next[BIT_MASK_HI] = PRIO_LVL0[1];
                    flags_next[BIT_MASK_LO] = PRIO_LVL0[0];
                end
                CCIRQ_OP_MASK_SET: begin
                    flags_next[BIT_MASK_HI] = PRIO_LVL3[1];
                    flags_next[BIT_MASK_LO] = PRIO_LVL3[0];
                end
                CCIRQ_OP_RET, CCIRQ_OP_POP: begin
                    flags_next = op_pop_data | FLAGS_ONE_MASK;
                    if (op_code == CCIRQ_OP_RET && depth_reg != 3'h0) begin
                        depth_next = depth_reg - 3'h1;
                    end
                end
                CCIRQ_OP_HALT, CCIRQ_OP_WAIT: begin
                    flags_next[BIT_MASK_HI] = op_mask_data[1];
                    flags_next[BIT_MASK_LO] = op_mask_data[0];
                    pwr_next = (op_code == CCIRQ_OP_HALT) ? CCIRQ_HALT : CCIRQ_WAIT;
                end
                default: ;
            endcase
        end

        if (pwr_reg != CCIRQ_RUN && win_any) begin
            pwr_next = CCIRQ_RUN;
            from_halt_next = pwr_reg == CCIRQ_HALT;
        end

        if (!take_reg && win_any && win_lvl > cur_lvl && (nested_reg || depth_reg == 3'h0)
            && (!from_halt_reg || haltcap_reg[win_src])) begin
            take_next = 1'b1;
            src_next  = win_src;
        end else if (take_reg && irq_ack) begin
            take_next = 1'b0;
            from_halt_next = 1'b0;
            depth_next = depth_reg + 3'h1;
            flags_next[BIT_MASK_HI] = prio_reg[2*src_reg + 1];
            flags_next[BIT_MASK_LO] = prio_reg[2*src_reg];
        end

        // wishbone register access
        if (wb_req) begin
            ack_next = mapped;
            err_next = !mapped;
            if (wb_we_i && mapped) begin
                case (wb_adr_i)
                    ADR_FLAGS:   if (wb_sel_i[0]) flags_next = wb_dat_i[7:0] | FLAGS_ONE_MASK;
                    ADR_PRIO: begin
                        if (wb_sel_i[0]) prio_next[7:0]  = wb_dat_i[7:0];
                        if (wb_sel_i[1]) prio_next[11:8] = wb_dat_i[11:8];
                    end
                    ADR_HALTCAP: if (wb_sel_i[0]) haltcap_next = wb_dat_i[5:0];
                    ADR_CTRL:    if (wb_sel_i[0]) nested_next = wb_dat_i[0];
                    default: ;
                endcase
            end else if (mapped) begin
                case (wb_adr_i)
                    ADR_FLAGS:   rdat_next = {24'h0, flags_reg | FLAGS_ONE_MASK};
                    ADR_PRIO:    rdat_next = {20'h0, prio_reg};
                    ADR_HALTCAP: rdat_next = {26'h0, haltcap_reg};
                    ADR_STATUS:  rdat_next = {24'h0, take_reg, src_reg, depth_reg, from_halt_reg};
                    ADR_CTRL:    rdat_next = {31'h0, nested_reg};
                    default:     rdat_next = 32'h0;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flags_reg     <= FLAGS_RESET;
            prio_reg      <= PRIO_RESET;
            haltcap_reg   <= HALTCAP_RESET;
            nested_reg    <= 1'b0;
            depth_reg     <= 3'h0;
            from_halt_reg <= 1'b0;
            pwr_reg       <= CCIRQ_RUN;
            take_reg      <= 1'b0;
            src_reg       <= SRC_NONE;
            rdat_reg      <= 32'h0;
            ack_reg       <= 1'b0;
            err_reg       <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            prio_reg      <= prio_next;
            haltcap_reg   <= haltcap_next;
            nested_reg    <= nested_next;
            depth_reg     <= depth_next;
            from_halt_reg <= from_halt_next;
            pwr_reg       <= pwr_next;
            take_reg      <= take_next;
            src_reg       <= src_next;
            rdat_reg      <= rdat_next;
            ack_reg       <= ack_next;
            err_reg       <= err_next;
        end
    end

    assign flags_register = flags_reg;
    assign irq_take       = take_reg;
    assign irq_source     = src_reg;
    assign low_power      = pwr_reg != CCIRQ_RUN;
    assign in_halt        = pwr_reg == CCIRQ_HALT;
    assign wb_dat_o       = rdat_reg;
    assign wb_ack_o       = ack_reg;
    assign wb_err_o       = err_reg;
endmodule : ccirq_core

// >>> verification/ccirq_core_asserts.sv
// checker: flags and interrupt properties at the core ports
`timescale 1ns/1ps
module ccirq_core_asserts
    import ccirq_pkg::*;
(
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst_b,
    // datapath
    input wire logic                 op_valid,
    input wire ccirq_pkg::ccirq_op_e op_code,
    input wire logic [7:0]           op_result,
    input wire logic                 op_carry,
    input wire logic                 op_nibble_carry,
    // interrupt
    input wire logic                 irq_ack,
    input wire logic [7:0]           flags_register,
    input wire logic                 irq_take,
    input wire logic [2:0]           irq_source,
    input wire logic                 in_halt,
    // bus
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic                 wb_ack_o,
    input wire logic                 wb_err_o
);
    logic       bus_wr, res_msb, res_zero, is_scf, is_mset;
    logic [1:0] mask_pair;
    logic [6:0] upper7;
    assign bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i;
    assign res_msb   = op_result[7];
    assign res_zero  = (op_result == 8'h00);
    assign is_scf    = (op_code == CCIRQ_OP_SCF);
    assign is_mset   = (op_code == CCIRQ_OP_MASK_SET);
    assign mask_pair = {flags_register[5], flags_register[3]};
    assign upper7    = flags_register[7:1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_ones_high: assert property (flags_register[7:6] == 2'h3)
        else $error("flags top bits not one");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered");
    a_add_flags: assert property (op_valid && op_code == CCIRQ_OP_ADD && !bus_wr
        |=> flags_register[4] == $past(op_nibble_carry) && flags_register[0] == $past(op_carry))
        else $error("add nibble or carry wrong");
    a_nz_flags: assert property (op_valid && !bus_wr && op_code inside {CCIRQ_OP_ADD, CCIRQ_OP_ARITH,
        CCIRQ_OP_LOGIC, CCIRQ_OP_SHIFT} |=> flags_register[2] == $past(res_msb) && flags_register[1] == $past(res_zero))
        else $error("negative or zero flag wrong");
    a_carry_force: assert property (op_valid && !bus_wr && op_code inside {CCIRQ_OP_SCF, CCIRQ_OP_RCF}
        |=> flags_register[0] == $past(is_scf))
        else $error("forced carry wrong");
    a_mask_ops: assert property (op_valid && !bus_wr && !irq_ack
        && op_code inside {CCIRQ_OP_MASK_CLR, CCIRQ_OP_MASK_SET} |=> mask_pair == ($past(is_mset) ? 2'h3 : 2'h2))
        else $error("mask op result wrong");
    a_keep_flags: assert property (op_valid && !bus_wr && !irq_ack && op_code == CCIRQ_OP_BTJ
        |=> upper7 == $past(upper7))
        else $error("bit test changed other flags");
    a_offer_holds: assert property (irq_take && !irq_ack |=> irq_take && $stable(irq_source))
        else $error("offer dropped before ack");
    a_no_take_off: assert property (mask_pair == 2'h3 && !irq_take |=> !irq_take)
        else $error("entry offered while disabled");
    c_entry: cover property (irq_take && irq_ack);
    c_halt: cover property ($rose(in_halt));
    c_err: cover property (wb_err_o);
endmodule : ccirq_core_asserts

bind ccirq_core ccirq_core_asserts asserts_u (.mclk, .rst_b, .op_valid, .op_code, .op_result, .op_carry,
    .op_nibble_carry, .irq_ack, .flags_register, .irq_take, .irq_source, .in_halt, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .wb_err_o);

// >>> verification/ccirq_irq_model.sv
// partner: datapath side answering interrupt entry offers
`timescale 1ns/1ps
module ccirq_irq_model #(
    parameter int ACK_DELAY = 1
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // entry handshake
    input  wire logic irq_take,
    output logic      irq_ack
);
    int cnt;
    // one-cycle accept after a delay, only while offered
    always_ff @(posedge mclk) begin
        if (!rst_b || irq_ack || !irq_take) begin
            cnt     <= 0;
            irq_ack <= 1'b0;
        end else if (cnt == ACK_DELAY) begin
            irq_ack <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : ccirq_irq_model

// >>> verification/ccirq_core_tb.sv
// testbench: flags updates, register bus and interrupt entry
`timescale 1ns/1ps
module ccirq_core_tb;
    import ccirq_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, op_carry = 1'b0, op_nibble_carry = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        irq_ack, irq_take, low_power, in_halt, wb_ack_o, wb_err_o, er;
    ccirq_op_e   op_code = CCIRQ_OP_NONE;
    logic [7:0]  op_result = 8'h00, op_pop_data = 8'h00, wb_adr_i = 8'h00, flags_register;
    logic [1:0]  op_mask_data = 2'h2;
    logic [5:0]  irq_pending = 6'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [2:0]  irq_source;
    int          num_errors = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    ccirq_core dut_u (.mclk, .rst_b, .op_valid, .op_code, .op_result, .op_carry, .op_nibble_carry, .op_pop_data,
        .op_mask_data, .irq_pending, .irq_ack, .flags_register, .irq_take, .irq_source, .low_power, .in_halt,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o);
    ccirq_irq_model #(.ACK_DELAY(2)) model_u (.mclk, .rst_b, .irq_take, .irq_ack);
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task finish_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, adr, d, 4'hf};
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        if (n >= 50) num_errors++;
    endtask : wb
    task op(input ccirq_op_e c, input logic [7:0] r, input logic cy, input logic [7:0] e);
        @(posedge mclk);
        {op_valid, op_code, op_result, op_pop_data, op_carry, op_nibble_carry} <= {1'b1, c, r, r, cy, cy};
        @(posedge mclk);
        op_valid <= 1'b0;
        #1 chk("flags", {24'h0, e}, {24'h0, flags_register});
    endtask : op
    task take(input logic [2:0] es);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (irq_ack !== 1'b1 && n < 40);
        chk("source", {29'h0, es}, {29'h0, irq_source});
        #1;
    endtask : take
    task t_regs;
        wb(1'b0, ADR_FLAGS, 32'h0); chk("flags rd", {24'h0, FLAGS_RESET}, rd);
        wb(1'b0, ADR_PRIO, 32'h0); chk("prio rd", {20'h0, PRIO_RESET}, rd);
        wb(1'b0, ADR_HALTCAP, 32'h0); chk("haltcap rd", {26'h0, HALTCAP_RESET}, rd);
        wb(1'b0, 8'h20, 32'h0); chk("unmapped", 32'h1, {31'h0, er});
        wb(1'b1, ADR_FLAGS, 32'h0); wb(1'b0, ADR_FLAGS, 32'h0); chk("ones", 32'hc0, rd);
    endtask : t_regs
    task t_flags;
        op(CCIRQ_OP_ADD, 8'h00, 1'b1, 8'hd3);
        op(CCIRQ_OP_LOGIC, 8'h80, 1'b0, 8'hd5);
        op(CCIRQ_OP_RCF, 8'h55, 1'b0, 8'hd4);
        op(CCIRQ_OP_SCF, 8'h00, 1'b0, 8'hd5);
        op(CCIRQ_OP_BTJ, 8'h00, 1'b0, 8'hd4);
        op(CCIRQ_OP_SHIFT, 8'h01, 1'b1, 8'hd1);
        op(CCIRQ_OP_ARITH, 8'hff, 1'b0, 8'hd4);
        op(CCIRQ_OP_ADD, 8'h7f, 1'b0, 8'hc0);
        op(CCIRQ_OP_MASK_SET, 8'h00, 1'b0, 8'he8);
        op(CCIRQ_OP_MASK_CLR, 8'h00, 1'b0, 8'he0);
        op(CCIRQ_OP_POP, 8'h08, 1'b0, 8'hc8);
    endtask : t_flags
    task t_irq;
        wb(1'b1, ADR_PRIO, 32'h0fc);
        wb(1'b1, ADR_CTRL, 32'h0);
        irq_pending <= 6'h21;
        take(3'h5);
        chk("entry mask", 32'hc0, {24'h0, flags_register});
        irq_pending <= 6'h11;
        op(CCIRQ_OP_RET, 8'he0, 1'b0, 8'he0);
        take(3'h0);
        chk("entry mask", 32'hc0, {24'h0, flags_register});
        irq_pending <= 6'h00;
        op(CCIRQ_OP_RET, 8'he8, 1'b0, 8'he8);
    endtask : t_irq
    task t_low_power;
        wb(1'b1, ADR_PRIO, 32'hffd);
        irq_pending <= 6'h02;
        op(CCIRQ_OP_HALT, 8'h00, 1'b0, 8'he0);
        repeat (5) @(posedge mclk);
        #1 chk("halt held", 32'h1, {31'h0, in_halt});
        irq_pending <= 6'h03;
        take(3'h0);
        repeat (5) @(posedge mclk);
        #1 chk("no preempt", 32'h0, {31'h0, irq_take});
        wb(1'b1, ADR_CTRL, 32'h1);
        take(3'h1);
        irq_pending <= 6'h00;
        op(CCIRQ_OP_RET, 8'he0, 1'b0, 8'he0);
        op(CCIRQ_OP_RET, 8'he0, 1'b0, 8'he0);
        op(CCIRQ_OP_WAIT, 8'h00, 1'b0, 8'he0);
        chk("wait entered", 32'h1, {31'h0, low_power});
        irq_pending <= 6'h10;
        take(3'h4);
        chk("wait left", 32'h0, {31'h0, low_power});
        irq_pending <= 6'h00;
    endtask : t_low_power
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_flags;
        t_irq;
        t_low_power;
        finish_test;
    end
    initial begin
        #200000;
        num_errors++;
        finish_test;
    end
endmodule : ccirq_core_tb
